// ==== design/seq_pkg.sv ====
// Purpose: Shared constants and types of the standby power sequencer.
// Assumes: 200 MHz clock, temperature in whole degrees C, 8-bit level.
// Notes: Durations are in seconds; they are reloaded from the
//   nonvolatile store at run time.
package seq_pkg;

  // Clock and time base
  localparam int CLK_HZ = 200_000_000;
  localparam int EIGHTH_MS = 125;
  localparam int TICK_CYC = CLK_HZ / 1000 * EIGHTH_MS;
  localparam int PRE_W = 25;
  localparam logic [2:0] EIGHTHS_LAST = 3'h7;
  localparam int BOOT_CYC = 16;

  // Display link: 100 kHz clock, four quarter phases per bit
  localparam int SCL_KHZ = 100;
  localparam int I2C_QTR_CYC = CLK_HZ / (SCL_KHZ * 1000 * 4);
  localparam int DISP_BYTES = 5;
  localparam logic [6:0] DISP_ADDR = 7'h3C;
  localparam logic [7:0] LOGO_ID = 8'h01; // Arbitrary value

  // Default durations and thresholds
  localparam int LOW_POWER_HOLD_MIN = 8;
  localparam int OFF_MIN = 2;
  localparam int MUTE_MIN = 10;
  localparam int BACKLIGHT_S = 15;
  localparam int TRIP_C = 70;
  localparam int HYST_K = 4;
  localparam logic [7:0] LEVEL_THR_RST = 8'h10;

  typedef enum logic [2:0] {
    ST_BOOT, ST_SEQ, ST_ON, ST_LOW_POWER_HOLD, ST_OFF, ST_HOT
  } mode_t;

  typedef struct packed {
    logic [15:0] quiet_s;     // ON to standby
    logic [15:0] low_power_hold_s;      // Standby to OFF
    logic [15:0] mute_s;      // Mute held low to OFF
    logic [15:0] backlight_s; // OFF to backlight dark
    logic [7:0] level_thr;
    logic [7:0] trip_c;
    logic [7:0] hyst_k;
  } cfg_t;

  localparam cfg_t CFG_RST = '{
    quiet_s: 16'(LOW_POWER_HOLD_MIN * 60),
    low_power_hold_s: 16'(OFF_MIN * 60),
    mute_s: 16'(MUTE_MIN * 60),
    backlight_s: 16'(BACKLIGHT_S),
    level_thr: LEVEL_THR_RST,
    trip_c: 8'(TRIP_C),
    hyst_k: 8'(HYST_K)
  };

  typedef struct packed {
    logic scl_o;
    logic scl_oe_n;
    logic sda_o;
    logic sda_oe_n;
  } i2c_pins_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic val;
  } sync_state_t;

  typedef enum logic [2:0] {
    I2_IDLE, I2_START, I2_BIT, I2_ACK, I2_STOP
  } i2c_st_t;

  typedef struct packed {
    i2c_st_t st;
    logic [9:0] div;
    logic [1:0] qtr;
    logic [2:0] bitn;
    logic [2:0] byten;
    logic [7:0] sh;
    logic scl;
    logic sda;
  } i2c_state_t;

  typedef struct packed {
    mode_t mode;
    logic [PRE_W-1:0] pre;
    logic [2:0] eighth;
    logic [3:0] phase;
    logic [4:0] boot;
    logic [15:0] quiet;
    logic [15:0] mute_cnt;
    logic [19:0] off_e;
    logic off_by_mute;
    logic [1:0] remote;
    logic hold;
    logic supply;
    logic backlight;
    logic lamp;
    logic fault;
    logic mute_drv;
    logic disp_go;
  } seq_state_t;

endpackage

// ==== design/pin_sync.sv ====
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Input is asynchronous to clock.
// Notes: Output changes only when stages two and three agree.
`timescale 1ns/1ps
module pin_sync import seq_pkg::*; #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clock, // System clock
  input wire logic nrst,  // Async reset, active low
  input wire logic pin,   // Raw pin level
  output logic val        // Filtered level
);
  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.val = s_q.s3;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, val: RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign val = s_q.val;
endmodule // pin_sync

// ==== design/i2c_display_tx.sv ====
// Purpose: Write-only I2C master sending one status frame to a display.
// Assumes: No clock stretching; acknowledge bits are not checked.
// Notes: Open-drain pins; enable low pulls the line low.
`timescale 1ns/1ps
module i2c_display_tx import seq_pkg::*; (
  input wire logic clock,                       // System clock
  input wire logic nrst,                        // Async reset, active low
  input wire logic start,                       // Pulse: send frame
  input wire logic [DISP_BYTES-1:0][7:0] frame, // Byte 4 sent first
  output logic busy,                            // Frame in progress
  output i2c_pins_t pins                        // Open-drain pins
);
  i2c_state_t s_q;
  i2c_state_t s_d;
  logic qtick;

  always_comb begin
    s_d = s_q;
    qtick = (s_q.div == 10'(I2C_QTR_CYC - 1));
    s_d.div = qtick ? 10'h0 : s_q.div + 10'h1;
    case (s_q.st)
      I2_IDLE: begin
        s_d.div = 10'h0;
        s_d.scl = 1'b1;
        s_d.sda = 1'b1;
        if (start) begin
          s_d.st = I2_START;
          s_d.qtr = 2'h0;
          s_d.byten = 3'(DISP_BYTES - 1);
          s_d.sh = frame[DISP_BYTES-1];
          s_d.bitn = 3'h7;
        end
      end
      I2_START: begin
        if (qtick) begin
          s_d.qtr = s_q.qtr + 2'h1;
          if (s_q.qtr == 2'h0) begin
            s_d.sda = 1'b0;
          end
          if (s_q.qtr == 2'h1) begin
            s_d.scl = 1'b0;
            s_d.st = I2_BIT;
            s_d.qtr = 2'h0;
          end
        end
      end
      I2_BIT, I2_ACK: begin
        if (qtick) begin
          s_d.qtr = s_q.qtr + 2'h1;
          case (s_q.qtr)
            2'h0: s_d.sda = (s_q.st == I2_ACK) ? 1'b1 : s_q.sh[7];
            2'h1: s_d.scl = 1'b1;
            2'h2: s_d.scl = 1'b1;
            default: begin
              s_d.scl = 1'b0;
              if (s_q.st == I2_ACK) begin
                if (s_q.byten == 3'h0) begin
                  s_d.st = I2_STOP;
                end else begin
                  s_d.st = I2_BIT;
                  s_d.byten = s_q.byten - 3'h1;
                  s_d.sh = frame[s_q.byten - 3'h1];
                  s_d.bitn = 3'h7;
                end
              end else if (s_q.bitn == 3'h0) begin
                s_d.st = I2_ACK;
              end else begin
                s_d.bitn = s_q.bitn - 3'h1;
                s_d.sh = {s_q.sh[6:0], 1'b0};
              end
            end
          endcase
        end
      end
      I2_STOP: begin
        if (qtick) begin
          s_d.qtr = s_q.qtr + 2'h1;
          case (s_q.qtr)
            2'h0: s_d.sda = 1'b0;
            2'h1: s_d.scl = 1'b1;
            2'h2: s_d.sda = 1'b1;
            default: s_d.st = I2_IDLE;
          endcase
        end
      end
      default: s_d.st = I2_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{st: I2_IDLE, scl: 1'b1, sda: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.st != I2_IDLE);
  assign pins = '{scl_o: 1'b0, scl_oe_n: s_q.scl,
                  sda_o: 1'b0, sda_oe_n: s_q.sda};
endmodule // i2c_display_tx

// ==== design/audio_standby_power_sequencer.sv ====
// Purpose: ON / standby / OFF sequencer driving amplifier remote lines,
//   lamps, internal supply, display backlight and display link.
// Assumes: audio_level, temp_c and nvm inputs are on the clock domain;
//   mute line and jumper are raw pins.
// Notes: Time base is an eighth-second tick; durations are seconds.
`timescale 1ns/1ps

// Functional notes
// - With auto power active and mute idle, detected audio wakes the system from an OFF not forced by mute.
// - Auto power on by default; installed disable jumper turns it off.
// - Mute held low at power-on starts in OFF until mute is released.
// - Mute idle at power-on: activate and switch equipment on in order.
// - With auto power, stay ON while the level exceeds the threshold.
// - Level continuously below threshold for 8 minutes: ON to standby.
// - Two more quiet minutes in standby: switch to OFF.
// - Mute held low for more than 10 minutes forces OFF.
// - Durations and thresholds come from the nonvolatile store.
// - Mute, standby and OFF show distinct lamp patterns.
// - Over-temperature switches module and remote equipment OFF.
// - After cooling, the system reactivates by itself.
// - Over-temperature lights the fault lamp and shows on display.
// - Two remote on/off outputs driven only by this controller.
// - OFF mode also disables the internal supply.
// - Display backlight goes dark 15 seconds after entering OFF.
// - Display link shows mode, temperature, level and a logo.
// - Trip at 70 degrees C, re-enable after a 4 K fall.
module audio_standby_power_sequencer import seq_pkg::*; #(
  parameter int TICK_CYC_P = TICK_CYC
) (
  input wire logic clock,                 // 200 MHz system clock
  input wire logic nrst,                  // Async reset, active low
  input wire logic [7:0] audio_level,     // Detected input level
  input wire logic [7:0] temp_c,          // Module temperature, deg C
  input wire cfg_t nvm_cfg,               // Stored durations, thresholds
  input wire logic nvm_valid,             // Stored set is loaded
  input wire logic mute_i,                // Mute line level, low = mute
  output logic mute_o,                    // Mute line drive value
  output logic mute_oe_n,                 // Low while pulling mute low
  input wire logic detect_disable_jumper, // Low when jumper installed
  output logic [1:0] remote_on,           // Amplifier remote lines
  output logic low_power_hold,            // Standby line to amplifiers
  output logic supply_en,                 // Internal supply enable
  output logic backlight_en,              // Display backlight enable
  output logic status_lamp,               // Mode indicator lamp
  output logic fault_indicator_lamp,      // Over-temperature lamp
  output mode_t mode,                     // Current operating mode
  output i2c_pins_t disp_pins,            // Display link pins
  output logic disp_busy                  // Display frame in progress
);
  seq_state_t s_q;
  seq_state_t s_d;
  cfg_t cfg;
  logic mute_s;
  logic jumper_s;
  logic auto_on;
  logic ext_mute;
  logic loud;
  logic hot;
  logic cool;
  logic tick;
  logic sec;
  logic [7:0] cool_c;
  logic [DISP_BYTES-1:0][7:0] frame;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h1;
  endfunction

  pin_sync #(.RST_VAL(1'b1)) u_mute_sync (
    .clock(clock),
    .nrst(nrst),
    .pin(mute_i),
    .val(mute_s)
  );

  pin_sync #(.RST_VAL(1'b1)) u_jumper_sync (
    .clock(clock),
    .nrst(nrst),
    .pin(detect_disable_jumper),
    .val(jumper_s)
  );

  // Stored set replaces the defaults once loaded
  assign cfg = nvm_valid ? nvm_cfg : CFG_RST;
  assign auto_on = jumper_s;
  assign ext_mute = !mute_s && !s_q.mute_drv;
  assign loud = (audio_level > cfg.level_thr);
  assign cool_c = (cfg.trip_c > cfg.hyst_k) ?
                  cfg.trip_c - cfg.hyst_k : 8'h00;
  assign hot = (temp_c >= cfg.trip_c);
  assign cool = (temp_c <= cool_c);

  always_comb begin
    s_d = s_q;
    s_d.disp_go = 1'b0;
    tick = (s_q.pre == PRE_W'(TICK_CYC_P - 1));
    sec = tick && (s_q.eighth == EIGHTHS_LAST);
    s_d.pre = tick ? '0 : s_q.pre + PRE_W'(1);
    if (tick) begin
      s_d.eighth = s_q.eighth + 3'h1;
      s_d.phase = s_q.phase + 4'h1;
    end
    if (!ext_mute) begin
      s_d.mute_cnt = 16'h0;
    end else if (sec) begin
      s_d.mute_cnt = sat_inc(s_q.mute_cnt);
    end
    case (s_q.mode)
      ST_BOOT: begin
        s_d.boot = s_q.boot + 5'h1;
        if (s_q.boot == 5'(BOOT_CYC - 1)) begin
          if (!mute_s) begin
            s_d.mode = ST_OFF;
            s_d.off_by_mute = 1'b1;
          end else begin
            s_d.mode = ST_SEQ;
          end
        end
      end
      ST_SEQ: begin
        // Supply first, then remote 0, remote 1, then release standby
        if (sec) begin
          if (!s_q.remote[0]) begin
            s_d.remote[0] = 1'b1;
          end else if (!s_q.remote[1]) begin
            s_d.remote[1] = 1'b1;
          end else begin
            s_d.mode = ST_ON;
            s_d.quiet = 16'h0;
          end
        end
      end
      ST_ON: begin
        if (loud) begin
          s_d.quiet = 16'h0;
        end else if (sec) begin
          s_d.quiet = sat_inc(s_q.quiet);
        end
        if (auto_on && !loud && s_q.quiet >= cfg.quiet_s) begin
          s_d.mode = ST_LOW_POWER_HOLD;
          s_d.quiet = 16'h0;
        end
      end
      ST_LOW_POWER_HOLD: begin
        if (loud) begin
          s_d.mode = ST_ON;
          s_d.quiet = 16'h0;
        end else begin
          if (sec) begin
            s_d.quiet = sat_inc(s_q.quiet);
          end
          if (s_q.quiet >= cfg.low_power_hold_s) begin
            s_d.mode = ST_OFF;
            s_d.off_by_mute = 1'b0;
          end
        end
      end
      ST_OFF: begin
        if (s_q.off_by_mute) begin
          if (mute_s) begin
            s_d.mode = ST_SEQ;
            s_d.off_by_mute = 1'b0;
          end
        end else if (auto_on && loud && mute_s) begin
          s_d.mode = ST_SEQ;
        end
      end
      ST_HOT: begin
        if (cool) begin
          s_d.mode = ST_SEQ;
        end
      end
      default: s_d.mode = ST_BOOT;
    endcase
    // Long external mute overrides audio in ON and standby
    if ((s_q.mode == ST_ON || s_q.mode == ST_LOW_POWER_HOLD) &&
        s_q.mute_cnt > cfg.mute_s) begin
      s_d.mode = ST_OFF;
      s_d.off_by_mute = 1'b1;
    end
    // Over-temperature wins over every other transition except those out of ST_BOOT and ST_HOT
    if (s_q.mode != ST_BOOT && s_q.mode != ST_HOT && hot) begin
      s_d.mode = ST_HOT;
      s_d.off_by_mute = 1'b0;
    end
    if (s_d.mode != ST_SEQ && s_d.mode != ST_ON &&
        s_d.mode != ST_LOW_POWER_HOLD) begin
      s_d.remote = 2'b00;
    end
    if (s_d.mode != ST_OFF) begin
      s_d.off_e = 20'h0;
    end else if (tick && s_q.mode == ST_OFF &&
                 s_q.off_e != 20'hFFFFF) begin
      s_d.off_e = s_q.off_e + 20'h1;
    end
    s_d.hold = (s_d.mode != ST_ON);
    s_d.supply = (s_d.mode == ST_SEQ || s_d.mode == ST_ON ||
                  s_d.mode == ST_LOW_POWER_HOLD);
    s_d.backlight = !(s_d.mode == ST_OFF &&
                      s_d.off_e >= {1'b0, cfg.backlight_s, 3'h0});
    s_d.mute_drv = (s_d.mode == ST_HOT);
    s_d.fault = (s_d.mode == ST_HOT);
    case (s_d.mode)
      ST_ON: s_d.lamp = ext_mute ? s_d.phase[0] : 1'b1;
      ST_LOW_POWER_HOLD: s_d.lamp = s_d.phase[2];
      ST_OFF: s_d.lamp = (s_d.phase == 4'h0);
      ST_SEQ: s_d.lamp = s_d.phase[1];
      default: s_d.lamp = 1'b0;
    endcase
    s_d.disp_go = sec;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{mode: ST_BOOT, hold: 1'b1, backlight: 1'b1,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Status frame: address, mode, temperature, level, logo
  assign frame = {{DISP_ADDR, 1'b0}, {5'h00, s_q.mode},
                  temp_c, audio_level, LOGO_ID};

  i2c_display_tx u_disp (
    .clock(clock),
    .nrst(nrst),
    .start(s_q.disp_go),
    .frame(frame),
    .busy(disp_busy),
    .pins(disp_pins)
  );

  assign mute_o = 1'b0;
  assign mute_oe_n = !s_q.mute_drv;
  assign remote_on = s_q.remote;
  assign low_power_hold = s_q.hold;
  assign supply_en = s_q.supply;
  assign backlight_en = s_q.backlight;
  assign status_lamp = s_q.lamp;
  assign fault_indicator_lamp = s_q.fault;
  assign mode = s_q.mode;
endmodule // audio_standby_power_sequencer

// ==== bench/seq_props.sv ====
// Purpose: Port assertions for the standby power sequencer.
// Assumes: Bound to the top module; one clock domain.
// Notes: Thresholds follow the active configuration.
`timescale 1ns/1ps
module seq_props import seq_pkg::*; #(
  parameter int TICK_CYC_P = TICK_CYC
) (
  input wire logic clock, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [7:0] audio_level, // Level
  input wire logic [7:0] temp_c, // Temperature
  input wire cfg_t nvm_cfg, // Stored set
  input wire logic nvm_valid, // Stored set valid
  input wire logic mute_oe_n, // Mute pull enable
  input wire logic [1:0] remote_on, // Remote lines
  input wire logic low_power_hold, // Standby line
  input wire logic supply_en, // Supply enable
  input wire logic backlight_en, // Backlight
  input wire logic fault_indicator_lamp, // Fault lamp
  input wire mode_t mode // Mode
);
  cfg_t cfg;
  logic [31:0] seq_cyc_q;
  assign cfg = nvm_valid ? nvm_cfg : CFG_RST;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      seq_cyc_q <= 32'h0;
    else if (mode == ST_SEQ)
      seq_cyc_q <= seq_cyc_q + 32'h1;
    else
      seq_cyc_q <= 32'h0;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence off_entry_s;
    mode != ST_OFF ##1 mode == ST_OFF;
  endsequence
  sequence lit_s;
    backlight_en [*8];
  endsequence
  sequence seq_done_s;
    mode == ST_SEQ ##1 mode == ST_ON;
  endsequence
  hot_outputs_a: assert property (
    mode == ST_HOT |-> remote_on == 2'h0 && !supply_en
      && fault_indicator_lamp && !mute_oe_n)
    else $error("Hot mode outputs wrong");
  trip_entry_a: assert property (
    mode != ST_BOOT && mode != ST_HOT && temp_c >= cfg.trip_c
      |=> mode == ST_HOT)
    else $error("Over-temperature not taken");
  hot_hold_a: assert property (
    mode == ST_HOT && temp_c > cfg.trip_c - cfg.hyst_k
      |=> mode == ST_HOT)
    else $error("Hot mode left too early");
  off_supply_a: assert property (
    mode == ST_OFF |-> !supply_en && remote_on == 2'h0)
    else $error("Supply or remote on in OFF");
  hold_line_a: assert property (
    (mode == ST_ON) == !low_power_hold)
    else $error("Standby line disagrees with mode");
  remote_order_a: assert property (
    $rose(remote_on[1]) |-> $past(remote_on[0]))
    else $error("Remote lines out of order");
  seq_length_a: assert property (
    seq_done_s |-> seq_cyc_q >= 32'(16 * TICK_CYC_P))
    else $error("Switch-on order too short");
  low_power_hold_wake_a: assert property (
    mode == ST_LOW_POWER_HOLD && audio_level > cfg.level_thr
      && temp_c < cfg.trip_c |=> mode == ST_ON)
    else $error("Standby did not wake");
  backlight_a: assert property (
    off_entry_s |-> lit_s)
    else $error("Backlight dark too soon");
  dark_off_a: assert property (
    !backlight_en |-> mode == ST_OFF)
    else $error("Backlight dark outside OFF");
  mute_drive_a: assert property (
    !mute_oe_n |-> mode == ST_HOT)
    else $error("Mute pulled outside hot mode");
endmodule // seq_props

// ==== bench/amp_partner.sv ====
// Purpose: External amplifiers on the mute and remote lines.
// Assumes: Mute line has a pull-up.
// Notes: Holds mute low only when the bench commands it.
`timescale 1ns/1ps
module amp_partner import seq_pkg::*; (
  input wire logic pull_req, // Command: hold mute low
  input wire logic mute_o, // Device mute drive value
  input wire logic mute_oe_n, // Device pulls mute when low
  input wire logic [1:0] remote_on, // Remote lines
  input wire logic low_power_hold, // Standby line
  output logic mute_i, // Resolved mute line
  output logic [1:0] amp_live // Amplifiers running
);
  // Wired-and of both pullers over the pull-up
  assign mute_i = !pull_req && (mute_oe_n || mute_o);
  assign amp_live = remote_on & {2{!low_power_hold}};
endmodule // amp_partner

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench for the standby power sequencer.
// Assumes: Short tick and short stored durations.
// Notes: Audio level is redrawn every cycle.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module testbench import seq_pkg::*;;
  localparam int TK = 4;
  localparam int SEC = 8 * TK;
  localparam int LIMIT = 60000;
  // Address, ack slot, mode byte, ack slot, temperature byte
  localparam logic [25:0] DISP_EXP = {DISP_ADDR, 1'b0, 1'b1, 5'h00,
    ST_ON, 1'b1, 8'h19};
  localparam cfg_t CFG = '{quiet_s: 16'h3, low_power_hold_s: 16'h2, mute_s: 16'h2,
    backlight_s: 16'h1, level_thr: 8'h10, trip_c: 8'h46, hyst_k: 8'h4};
  logic clock, nrst, mute_i, mute_o, mute_oe_n, jumper, hold_line;
  logic supply_en, backlight_en, lamp, fault, pull_req, loud;
  logic [7:0] audio_level, temp_c;
  logic [1:0] remote_on, amp_live;
  logic nvm_valid, disp_busy, scl_q;
  logic [25:0] disp_sh;
  i2c_pins_t disp_pins;
  mode_t mode;
  int seed, mismatches, tests_run, cyc, disp_n;
  audio_standby_power_sequencer #(.TICK_CYC_P(TK)) i_dut (
    .clock(clock), .nrst(nrst), .audio_level(audio_level),
    .temp_c(temp_c), .nvm_cfg(CFG), .nvm_valid(nvm_valid),
    .mute_i(mute_i), .mute_o(mute_o), .mute_oe_n(mute_oe_n),
    .detect_disable_jumper(jumper), .remote_on(remote_on),
    .low_power_hold(hold_line), .supply_en(supply_en),
    .backlight_en(backlight_en), .status_lamp(lamp),
    .fault_indicator_lamp(fault), .mode(mode), .disp_pins(disp_pins),
    .disp_busy(disp_busy));
  amp_partner i_amp (.pull_req(pull_req), .mute_o(mute_o),
    .mute_oe_n(mute_oe_n), .remote_on(remote_on),
    .low_power_hold(hold_line), .mute_i(mute_i), .amp_live(amp_live));
  function automatic int secs(input int s);
    return s * SEC;
  endfunction
  function automatic int duty(input mode_t m, input logic mu, int len);
    if (m == ST_ON)
      return mu ? len / 2 : len;
    if (m == ST_LOW_POWER_HOLD)
      return len / 2;
    return len / 16;
  endfunction
  task automatic finish_test();
    $display("Counts: %0d run, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wait_mode(input mode_t m, input int lo, hi, string nm);
    int n;
    n = 0;
    while (mode !== m && n < hi) begin
      @(negedge clock);
      n++;
    end
    `CHK(nm, 1'b1, mode === m && n >= lo)
  endtask
  task automatic lamp_count(input int len, exp, string nm);
    int c;
    c = 0;
    repeat (len) begin
      @(negedge clock);
      c += (lamp === 1'b1);
    end
    `CHK(nm, exp, c)
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    hold(5);
    nrst = 1'b1;
  endtask
  task automatic done(input string nm);
    $display("Test %s done", nm);
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      mismatches++;
      finish_test();
    end
  end
  always @(negedge clock) begin
    audio_level <= loud ? 8'h11 + 8'($unsigned($random(seed)) % 239)
      : 8'($unsigned($random(seed)) % 17);
  end
  // Display link: line level is the enable; sample sda at the first 26 scl rises after reset
  always @(negedge clock) begin
    scl_q <= disp_pins.scl_oe_n;
    if (!nrst) begin
      disp_n <= 0;
    end else if (disp_pins.scl_oe_n && !scl_q && disp_n < 26) begin
      disp_sh <= {disp_sh[24:0], disp_pins.sda_oe_n};
      disp_n <= disp_n + 1;
    end
  end
  initial begin
    int bl;
    seed = 33430;
    nrst = 1'b0;
    loud = 1'b0;
    audio_level = 8'h0;
    nvm_valid = 1'b1;
    temp_c = 8'h19;
    jumper = 1'b1;
    pull_req = 1'b0;
    do_reset();
    wait_mode(ST_SEQ, 15, 20, "boot");
    `CHK("supply", 1'b1, supply_en)
    loud = 1'b1;
    wait_mode(ST_ON, secs(2), secs(3) + 8, "seq");
    `CHK("amps", 2'h3, amp_live)
    hold(secs(5));
    `CHK("stay", ST_ON, mode)
    lamp_count(64, duty(ST_ON, 0, 64), "lamp on");
    done("power-up");
    loud = 1'b0;
    wait_mode(ST_LOW_POWER_HOLD, secs(2) - 4, secs(4) + 8, "quiet");
    lamp_count(32, duty(ST_LOW_POWER_HOLD, 0, 32), "lamp low_power_hold");
    loud = 1'b1;
    hold(3);
    `CHK("wake", ST_ON, mode)
    loud = 1'b0;
    wait_mode(ST_LOW_POWER_HOLD, secs(2) - 4, secs(4) + 8, "restart");
    wait_mode(ST_OFF, secs(1) - 4, secs(3) + 8, "off");
    `CHK("supply off", 1'b0, supply_en)
    `CHK("lit", 1'b1, backlight_en)
    bl = 0;
    while (backlight_en !== 1'b0 && bl < 60) begin
      @(negedge clock);
      bl++;
    end
    `CHK("dark", 1'b1, bl >= secs(1) - 8 && bl < secs(1) + 8)
    lamp_count(64, duty(ST_OFF, 0, 64), "lamp off");
    done("standby");
    loud = 1'b1;
    wait_mode(ST_SEQ, 1, 8, "auto on");
    wait_mode(ST_ON, secs(2), secs(3) + 8, "seq2");
    jumper = 1'b0;
    loud = 1'b0;
    hold(secs(6));
    `CHK("jumper", ST_ON, mode)
    done("jumper");
    loud = 1'b1;
    pull_req = 1'b1;
    hold(8);
    lamp_count(32, duty(ST_ON, 1, 32), "lamp mute");
    wait_mode(ST_OFF, 16, secs(3) + 8, "mute off");
    hold(secs(2));
    `CHK("held", ST_OFF, mode)
    pull_req = 1'b0;
    wait_mode(ST_SEQ, 3, 12, "unmute");
    jumper = 1'b1;
    wait_mode(ST_ON, secs(2), secs(3) + 8, "seq3");
    done("mute");
    // Default quiet time is minutes long, so ON must hold
    nvm_valid = 1'b0;
    loud = 1'b0;
    hold(secs(6));
    `CHK("stored", ST_ON, mode)
    loud = 1'b1;
    hold(4);
    nvm_valid = 1'b1;
    done("stored set");
    temp_c = 8'h45;
    hold(8);
    `CHK("warm", ST_ON, mode)
    temp_c = 8'h46;
    wait_mode(ST_HOT, 1, 4, "trip");
    `CHK("amps hot", 2'h0, amp_live)
    `CHK("fault", 1'b1, fault)
    `CHK("mute hot", 1'b0, mute_i)
    temp_c = 8'h43;
    hold(secs(1));
    `CHK("hyst", ST_HOT, mode)
    temp_c = 8'h42;
    wait_mode(ST_SEQ, 1, 4, "cool");
    temp_c = 8'h19;
    done("temperature");
    pull_req = 1'b1;
    do_reset();
    wait_mode(ST_OFF, 15, 20, "muted boot");
    hold(secs(2));
    `CHK("muted stay", ST_OFF, mode)
    pull_req = 1'b0;
    wait_mode(ST_SEQ, 3, 12, "release");
    done("muted power-on");
    while (disp_n < 26) @(negedge clock);
    `CHK("display", DISP_EXP, disp_sh)
    `CHK("disp busy", 1'b1, disp_busy)
    done("display");
    finish_test();
  end
endmodule // testbench
bind audio_standby_power_sequencer seq_props #(
  .TICK_CYC_P(TICK_CYC_P)) i_props (.clock(clock), .nrst(nrst),
  .audio_level(audio_level), .temp_c(temp_c), .nvm_cfg(nvm_cfg),
  .nvm_valid(nvm_valid), .mute_oe_n(mute_oe_n), .remote_on(remote_on),
  .low_power_hold(low_power_hold), .supply_en(supply_en),
  .backlight_en(backlight_en),
  .fault_indicator_lamp(fault_indicator_lamp), .mode(mode));
